// *** hw/node_address_defines.vh ***
// Constants for node address and mode selection
`ifndef NODE_ADDRESS_DEFINES_VH
`define NODE_ADDRESS_DEFINES_VH
`define POS_ADDR_FIRST 16'hffff
`define FIXED_ADDR_FIRST 16'h03e9
`define ALIAS_MIN 8'h01
`define ALIAS_MAX 8'hff
`define NODE_MAX 8'h7f
`define NODE_MASTER 7'h00
`define MODE_PROF_POS 8'h01
`define MODE_PROF_VEL 8'h03
`define MODE_PROF_TRQ 8'h04
`define MODE_HOMING 8'h06
`define MODE_PTI 8'h07
`define SEL_NONE 3'h0
`define SEL_PROF_POS 3'h1
`define SEL_PROF_VEL 3'h2
`define SEL_PROF_TRQ 3'h3
`define SEL_HOMING 3'h4
`define SEL_PTI 3'h5
`define SEL_FIELD_W 4
`define FIXED_RST 16'h0000
`define ALIAS_RST 8'h00
`define NODE_RST 7'h00
`endif

// *** hw/node_address_and_mode_select.v ***
// Node identity resolution and motion mode decode for a drive node
// Function
// - Position addressing: first node 0xffff, each later node one lower.
// - Station alias from two switches, valid 0x01 through 0xff.
// - Dual axis is one node; second axis copies first axis alias.
// - Fixed address and alias are always both usable.
// - CAN node number is seven bits, valid range 1 to 127.
// - Node zero reserved for master; only as multi-drop gateway.
// - Node number is the sum of switches, inputs and flash value.
// - Zero to seven configurable digital inputs contribute to node number.
// - Switches alone may set any node number up to 127.
// - Mode numbers 1,3,4,6,7 select position, velocity, torque, homing, interpolation.
// - Profile position runs a complete move on command.
// - Profile velocity accelerates to set speed, decelerates on halt.
// - Profile torque ramps to new value, ramps down on halt.
// - Interpolated mode joins points with cubic segments.
// - Homing uses configurable index, home and limit switches.
// - Serial port is three-wire, terminal side, full duplex.
// - Tool-started serial moves may suspend network operations until stopped.
`include "node_address_defines.vh"
`default_nettype none

module node_address_and_mode_select #(
    parameter NUM_INPUTS = 16
) (
    input wire clk,
    input wire arst_n,
    input wire clk_en,
    input wire [15:0] chain_position,
    input wire [15:0] fixed_addr_in,
    input wire fixed_addr_load,
    input wire [3:0] alias_switch_high,
    input wire [3:0] alias_switch_low,
    input wire second_axis,
    input wire [7:0] first_axis_alias,
    input wire [6:0] node_switch,
    input wire [NUM_INPUTS-1:0] digital_in,
    input wire [2:0] input_count,
    input wire [4*7-1:0] input_select,
    input wire [6:0] flash_node,
    input wire gateway_mode,
    input wire [7:0] mode_number,
    input wire tool_move_active,
    output reg [15:0] position_addr_q,
    output reg [15:0] fixed_addr_q,
    output reg [7:0] station_alias_q,
    output reg alias_valid_q,
    output reg [6:0] node_number_q,
    output reg node_valid_q,
    output reg [2:0] mode_sel_q,
    output reg mode_valid_q,
    output reg network_suspend_q,
    output reg serial_full_duplex_q
);

    // Pins are asynchronous: two stages before use
    wire [3:0] ash_s2;
    wire [3:0] asl_s2;
    wire [6:0] nsw_s2;
    wire [NUM_INPUTS-1:0] din_s2;

    pin_sync #(
        .W(4)
    ) u_sync_ash (
        .clk(clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .d(alias_switch_high),
        .q(ash_s2)
    );

    pin_sync #(
        .W(4)
    ) u_sync_asl (
        .clk(clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .d(alias_switch_low),
        .q(asl_s2)
    );

    pin_sync #(
        .W(7)
    ) u_sync_nsw (
        .clk(clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .d(node_switch),
        .q(nsw_s2)
    );

    pin_sync #(
        .W(NUM_INPUTS)
    ) u_sync_din (
        .clk(clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .d(digital_in),
        .q(din_s2)
    );

    // Digital input contribution: each node bit picks one input
    // A count below seven leaves the high bits at zero
    wire [6:0] din_value;

    node_bit_pick #(
        .N(NUM_INPUTS)
    ) u_pick_0 (
        .bit_index(3'h0),
        .input_count(input_count),
        .select(input_select[`SEL_FIELD_W*0 +: `SEL_FIELD_W]),
        .inputs(din_s2),
        .bit_out(din_value[0])
    );

    node_bit_pick #(
        .N(NUM_INPUTS)
    ) u_pick_1 (
        .bit_index(3'h1),
        .input_count(input_count),
        .select(input_select[`SEL_FIELD_W*1 +: `SEL_FIELD_W]),
        .inputs(din_s2),
        .bit_out(din_value[1])
    );

    node_bit_pick #(
        .N(NUM_INPUTS)
    ) u_pick_2 (
        .bit_index(3'h2),
        .input_count(input_count),
        .select(input_select[`SEL_FIELD_W*2 +: `SEL_FIELD_W]),
        .inputs(din_s2),
        .bit_out(din_value[2])
    );

    node_bit_pick #(
        .N(NUM_INPUTS)
    ) u_pick_3 (
        .bit_index(3'h3),
        .input_count(input_count),
        .select(input_select[`SEL_FIELD_W*3 +: `SEL_FIELD_W]),
        .inputs(din_s2),
        .bit_out(din_value[3])
    );

    node_bit_pick #(
        .N(NUM_INPUTS)
    ) u_pick_4 (
        .bit_index(3'h4),
        .input_count(input_count),
        .select(input_select[`SEL_FIELD_W*4 +: `SEL_FIELD_W]),
        .inputs(din_s2),
        .bit_out(din_value[4])
    );

    node_bit_pick #(
        .N(NUM_INPUTS)
    ) u_pick_5 (
        .bit_index(3'h5),
        .input_count(input_count),
        .select(input_select[`SEL_FIELD_W*5 +: `SEL_FIELD_W]),
        .inputs(din_s2),
        .bit_out(din_value[5])
    );

    node_bit_pick #(
        .N(NUM_INPUTS)
    ) u_pick_6 (
        .bit_index(3'h6),
        .input_count(input_count),
        .select(input_select[`SEL_FIELD_W*6 +: `SEL_FIELD_W]),
        .inputs(din_s2),
        .bit_out(din_value[6])
    );

    // Sum kept two bits wider so overflow is seen, not wrapped
    wire [8:0] node_sum = {2'h0, nsw_s2} + {2'h0, din_value} + {2'h0, flash_node};
    wire node_overflow = (node_sum > {1'h0, `NODE_MAX});
    wire node_is_master = (node_sum[6:0] == `NODE_MASTER);
    // Alias switches are nibbles, high switch first
    wire [7:0] own_alias = {ash_s2, asl_s2};
    wire [7:0] alias_d = second_axis ? first_axis_alias : own_alias;

    reg [2:0] mode_sel_d;
    always @* begin
        case (mode_number)
            `MODE_PROF_POS: mode_sel_d = `SEL_PROF_POS;
            `MODE_PROF_VEL: mode_sel_d = `SEL_PROF_VEL;
            `MODE_PROF_TRQ: mode_sel_d = `SEL_PROF_TRQ;
            `MODE_HOMING: mode_sel_d = `SEL_HOMING;
            `MODE_PTI: mode_sel_d = `SEL_PTI;
            default: mode_sel_d = `SEL_NONE;
        endcase
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            position_addr_q <= `POS_ADDR_FIRST;
        end else if (clk_en) begin
            position_addr_q <= `POS_ADDR_FIRST - chain_position;
        end
    end

    // Fixed address is stored whatever scheme is in use
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            fixed_addr_q <= `FIXED_RST;
        end else if (clk_en && fixed_addr_load) begin
            fixed_addr_q <= fixed_addr_in;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            station_alias_q <= `ALIAS_RST;
        end else if (clk_en) begin
            station_alias_q <= alias_d;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            alias_valid_q <= 1'h0;
        end else if (clk_en) begin
            alias_valid_q <= (alias_d >= `ALIAS_MIN) && (alias_d <= `ALIAS_MAX);
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            node_number_q <= `NODE_RST;
        end else if (clk_en) begin
            node_number_q <= node_sum[6:0];
        end
    end

    // Zero allowed only as gateway; overflow refused rather than wrapped
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            node_valid_q <= 1'h0;
        end else if (clk_en) begin
            node_valid_q <= !node_overflow && (!node_is_master || gateway_mode);
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_sel_q <= `SEL_NONE;
        end else if (clk_en) begin
            mode_sel_q <= mode_sel_d;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_valid_q <= 1'h0;
        end else if (clk_en) begin
            mode_valid_q <= (mode_sel_d != `SEL_NONE);
        end
    end

    // Plain level: network work resumes as soon as the tool move ends
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            network_suspend_q <= 1'h0;
        end else if (clk_en) begin
            network_suspend_q <= tool_move_active;
        end
    end

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            serial_full_duplex_q <= 1'h0;
        end else if (clk_en) begin
            serial_full_duplex_q <= 1'h1;
        end
    end

endmodule // node_address_and_mode_select

module pin_sync #(
    parameter W = 1
) (
    input wire clk,
    input wire arst_n,
    input wire clk_en,
    input wire [W-1:0] d,
    output wire [W-1:0] q
);
    // Only the second stage is read; the first may be metastable
    reg [W-1:0] meta_q;
    reg [W-1:0] sync_q;

    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= {W{1'h0}};
            sync_q <= {W{1'h0}};
        end else if (clk_en) begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end

    assign q = sync_q;

endmodule // pin_sync

module node_bit_pick #(
    parameter N = 16
) (
    input wire [2:0] bit_index,
    input wire [2:0] input_count,
    input wire [3:0] select,
    input wire [N-1:0] inputs,
    output wire bit_out
);
    // Bits past the configured count contribute nothing
    // Select must stay below N; no range guard to keep it small
    assign bit_out = (bit_index < input_count) ? inputs[select] : 1'h0;

endmodule // node_bit_pick
`default_nettype wire

// *** verif/node_addr_checker.sv ***
// Assertions on node address and mode select ports
`default_nettype none
module node_addr_checker (
    input wire logic clk, arst_n, clk_en, fixed_addr_load, tool_move_active,
    input wire logic [15:0] chain_position, fixed_addr_in, position_addr_q, fixed_addr_q,
    input wire logic [7:0] mode_number, station_alias_q,
    input wire logic [2:0] mode_sel_q,
    input wire logic alias_valid_q, mode_valid_q, network_suspend_q, serial_full_duplex_q
);
timeunit 1ns / 1ps;
default clocking @(posedge clk); endclocking
default disable iff (!arst_n || !clk_en);
pos_addr_a: assert property (1 |=> position_addr_q == 16'hffff - $past(chain_position))
    else $error("position address wrong");
fixed_load_a: assert property (fixed_addr_load |=> fixed_addr_q == $past(fixed_addr_in))
    else $error("fixed address not stored");
fixed_keep_a: assert property (!fixed_addr_load |=> $stable(fixed_addr_q))
    else $error("fixed address lost");
alias_ok_a: assert property (alias_valid_q == (station_alias_q != 8'h00))
    else $error("alias valid wrong");
mode_vel_a: assert property (mode_number == 8'h03 |=> mode_valid_q && mode_sel_q == 3'h2)
    else $error("velocity mode not decoded");
mode_bad_a: assert property (mode_number == 8'h02 |=> !mode_valid_q)
    else $error("bad mode accepted");
net_hold_a: assert property (1 |=> network_suspend_q == $past(tool_move_active))
    else $error("suspend wrong");
duplex_on_a: assert property (1 |=> serial_full_duplex_q)
    else $error("duplex low");
cover property (mode_number == 8'h07 ##1 mode_valid_q);
cover property (fixed_addr_load);
cover property (tool_move_active ##1 network_suspend_q);
endmodule // node_addr_checker
bind node_address_and_mode_select node_addr_checker chk_i (.*);
`default_nettype wire

// *** verif/net_master_model.sv ***
// Network master handing out fixed addresses
`default_nettype none
module net_master_model (
    input wire logic clk,
    input wire logic scan,
    input wire logic [3:0] slot,
    output logic [15:0] fixed_addr_in,
    output logic fixed_addr_load
);
timeunit 1ns / 1ps;
initial {fixed_addr_in, fixed_addr_load} = 17'h00000;
always @(posedge clk) begin
    fixed_addr_load <= scan;
    // Idle bus toggles so stale data never looks valid
    fixed_addr_in <= scan ? 16'h03e9 + {12'h000, slot} : ~fixed_addr_in;
end
endmodule // net_master_model
`default_nettype wire

// *** verif/testbench.sv ***
// Self-checking bench for node address and mode select
`default_nettype none
module testbench;
timeunit 1ns / 1ps;
logic clk = 0, arst_n = 0, clk_en = 1, scan = 0, second_axis = 0, gateway_mode = 0;
logic tool_move_active = 0, fixed_addr_load, alias_valid_q, node_valid_q, mode_valid_q;
logic network_suspend_q, serial_full_duplex_q;
logic [3:0] slot = 0, alias_switch_high = 0, alias_switch_low = 0;
logic [15:0] chain_position = 0, digital_in = 0, fixed_addr_in, position_addr_q, fixed_addr_q;
logic [7:0] first_axis_alias = 0, mode_number = 0, station_alias_q, a;
logic [6:0] node_switch = 0, flash_node = 0, node_number_q;
logic [2:0] input_count = 0, mode_sel_q, e;
logic [27:0] input_select = 0;
logic [15:0] cp_hold;
logic [2:0] mt [0:7] = '{0, 1, 0, 2, 3, 0, 4, 5};
int fails = 0, checks_done = 0, cyc = 0, s, i, k;
node_address_and_mode_select dut (.*);
net_master_model master (.*);
initial forever #12.5 clk = ~clk;
always @(posedge clk) if (++cyc == 2000) begin
    fails++;
    report_and_stop;
end
task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
        fails++;
        $display("CHECK FAILED %0t got=%h exp=%h", $time, got, exp);
    end
endtask
task report_and_stop;
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
endtask
initial begin
    s = $urandom(32'h160d);
    repeat (16) @(negedge clk);
    arst_n = 1;
    for (k = 0; k < 4; k++) begin
        scan = 1;
        slot = k;
        repeat (3) @(negedge clk);
        chk(fixed_addr_q, 16'h03e9 + k);
    end
    scan = 0;
    for (k = 0; k < 60; k++) begin
        chain_position = $urandom;
        {alias_switch_high, alias_switch_low, first_axis_alias} = k ? $urandom : 0;
        {node_switch, digital_in, input_select} = {$urandom, $urandom};
        // Small flash share so sums land both sides of the limit
        flash_node = k % 3 ? $urandom % 32 : 0;
        input_count = k % 3 ? $urandom : 0;
        if (k % 7 == 1) {node_switch, flash_node, input_count} = 0;
        {tool_move_active, second_axis, gateway_mode} = k;
        mode_number = k < 9 ? k : $urandom;
        repeat (3) @(negedge clk);
        s = node_switch + flash_node;
        for (i = 0; i < input_count; i++) s += digital_in[input_select[4*i +: 4]] << i;
        a = second_axis ? first_axis_alias : {alias_switch_high, alias_switch_low};
        e = mode_number < 8 ? mt[mode_number] : 0;
        chk(position_addr_q, 16'hffff - chain_position);
        chk(fixed_addr_q, 16'h03ec);
        chk(station_alias_q, a);
        chk(alias_valid_q, a != 0);
        chk(node_number_q, s[6:0]);
        chk(node_valid_q, s <= 127 && (s != 0 || gateway_mode));
        chk(mode_sel_q, e);
        chk(mode_valid_q, e != 0);
        chk(network_suspend_q, tool_move_active);
        chk(serial_full_duplex_q, 1);
    end
    // Enable low must freeze the position address and suspend outputs
    cp_hold = chain_position;
    clk_en = 0;
    chain_position = ~chain_position;
    tool_move_active = ~tool_move_active;
    repeat (3) @(negedge clk);
    chk(position_addr_q, 16'hffff - cp_hold);
    chk(network_suspend_q, !tool_move_active);
    clk_en = 1;
    repeat (3) @(negedge clk);
    chk(position_addr_q, 16'hffff - chain_position);
    chk(network_suspend_q, tool_move_active);
    report_and_stop;
end
endmodule // testbench
`default_nettype wire
